// [motion_window_monitor.sv]
// Following error, target reached and speed threshold monitor of a motor drive.
// Assumes motion samples and object requests come from logic on the same clock.
// What this block does
// RULE1: Set status bit 13 when following error exceeds window longer than time-out.
// RULE2: Following error time-out is 16-bit, preset 0064h, must be exceeded.
// RULE3: With a reaction configured, raise the reaction and log an error entry.
// RULE4: In position modes set bit 10 after dwell inside the position window.
// RULE5: Position window all-ones switches target position monitoring off.
// RULE6: Position window time is 16-bit milliseconds, preset 0064h.
// RULE7: In profile velocity set bit 10 after dwell inside the velocity window.
// RULE8: Velocity window time is 16-bit milliseconds, preset 0000h.
// RULE9: Clear bit 12 after speed above threshold for threshold time, else one.
// RULE10: Velocity demand value reads back the ramp generator output.
// RULE11: Following error window all-ones switches following error monitoring off.
// RULE12: Millisecond tick from the clock; dwell timers restart when condition drops.
`include "motion_window_cfg.svh"

module motion_window_monitor
  import motion_window_pkg::*;
#(
  parameter int TICK_COUNT = `TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire op_mode_type       op_mode,
  input  wire motion_sample_type sample,
  input  wire object_req_type    req,
  output      object_rsp_type    rsp,
  output      logic [15:0]       drive_status_word,
  output      logic              following_error_reaction,
  output      logic              error_history
);

  localparam int TW = $clog2(TICK_COUNT + 1);

  logic [31:0]        following_error_window_q;
  logic [15:0]        following_error_timeout_q;
  logic [31:0]        position_window_q;
  logic [15:0]        position_window_time_q;
  logic [15:0]        velocity_window_q;
  logic [15:0]        velocity_window_time_q;
  logic [15:0]        velocity_threshold_q;
  logic [15:0]        velocity_threshold_time_q;
  logic [15:0]        reaction_code_q;
  logic [TW-1:0]      tick_count_q;
  logic               tick_q;
  logic [16:0]        dwell_q [3];
  logic [2:0]         cond;
  logic [2:0][15:0]   limit;
  logic               met [3];
  logic [31:0]        fe_abs;
  logic [31:0]        pos_abs;
  logic [31:0]        vel_dev_abs;
  logic [31:0]        vel_abs;
  logic               position_mode;
  logic               fe_flag_q;
  logic               object_ok;
  logic [31:0]        read_value;

  function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
    logic signed [32:0] d;
    d = 33'(a) - 33'(b);
    abs_diff = d[32] ? 32'(-d) : d[31:0];
  endfunction

  assign fe_abs        = abs_diff(sample.position_actual, sample.position_demand);
  assign pos_abs       = abs_diff(sample.position_actual, sample.target_position);
  assign vel_dev_abs   = abs_diff(sample.velocity_actual, sample.velocity_target);
  assign vel_abs       = abs_diff(sample.velocity_actual, 32'sh00000000);
  assign position_mode = (op_mode == mode_profile_position) ||
                         (op_mode == mode_interp_position);

  // Dwell conditions: 0 following error, 1 target reached, 2 speed above threshold
  always_comb begin
    cond[0] = (following_error_window_q != `WINDOW_OFF) &&
              (fe_abs > following_error_window_q); // RULE1 RULE11
    if (position_mode) begin
      cond[1] = (position_window_q != `WINDOW_OFF) &&
                (pos_abs < position_window_q); // RULE4 RULE5
    end else begin
      cond[1] = (op_mode == mode_profile_velocity) &&
                (vel_dev_abs < {16'h0000, velocity_window_q}); // RULE7
    end
    cond[2]  = vel_abs > {16'h0000, velocity_threshold_q}; // RULE9
    limit[0] = following_error_timeout_q; // RULE2
    limit[1] = position_mode ? position_window_time_q : velocity_window_time_q; // RULE6 RULE8
    limit[2] = velocity_threshold_time_q;
  end

  // Free-running millisecond tick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_count_q <= '0;
      tick_q       <= 1'b0;
    end else if (tick_count_q == TW'(TICK_COUNT - 1)) begin
      tick_count_q <= '0;
      tick_q       <= 1'b1; // RULE12
    end else begin
      tick_count_q <= tick_count_q + TW'(1);
      tick_q       <= 1'b0;
    end
  end

  // 17-bit counter saturates at 1FFFFh, above any 16-bit limit, so "longer than" is reachable
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_dwell
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          dwell_q[g] <= '0;
        end else if (!cond[g]) begin
          dwell_q[g] <= '0; // RULE12
        end else if (tick_q && dwell_q[g] != 17'h1FFFF) begin
          dwell_q[g] <= dwell_q[g] + 17'h00001;
        end
      end
      // Speed threshold is "for a time of", other dwells "longer than"
      if (g == 2) begin : g_ge
        assign met[g] = cond[g] && (dwell_q[g] >= {1'b0, limit[g]});
      end else begin : g_gt
        assign met[g] = cond[g] && (dwell_q[g] > {1'b0, limit[g]});
      end
    end
  endgenerate

  // Status word; the following error is flagged only while the deviation is outside the window longer than the time-out
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drive_status_word <= 16'h0000;
      drive_status_word[`STATUS_SPEED_ZERO_BIT] <= 1'b1;
      fe_flag_q <= 1'b0;
    end else begin
      drive_status_word <= 16'h0000;
      drive_status_word[`STATUS_FOLLOWING_ERROR_BIT] <= met[0]; // RULE1
      drive_status_word[`STATUS_TARGET_REACHED_BIT]  <= met[1]; // RULE4 RULE7
      drive_status_word[`STATUS_SPEED_ZERO_BIT]      <= !met[2]; // RULE9
      fe_flag_q <= met[0];
    end
  end

  // Reaction and history entry fire once on the rising edge of the error
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      following_error_reaction <= 1'b0;
      error_history            <= 1'b0;
    end else begin
      following_error_reaction <= met[0] && !fe_flag_q && (reaction_code_q != 16'h0000); // RULE3
      error_history            <= met[0] && !fe_flag_q && (reaction_code_q != 16'h0000); // RULE3
    end
  end

  // Object writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      following_error_window_q  <= `RST_FOLLOWING_ERROR_WINDOW;
      following_error_timeout_q <= `RST_FOLLOWING_ERROR_TIMEOUT;
      position_window_q         <= `RST_POSITION_WINDOW;
      position_window_time_q    <= `RST_POSITION_WINDOW_TIME;
      velocity_window_q         <= `RST_VELOCITY_WINDOW;
      velocity_window_time_q    <= `RST_VELOCITY_WINDOW_TIME;
      velocity_threshold_q      <= `RST_VELOCITY_THRESHOLD;
      velocity_threshold_time_q <= `RST_VELOCITY_THRESHOLD_TIME;
      reaction_code_q           <= `RST_FOLLOWING_ERROR_REACTION;
    end else if (req.write) begin
      unique case (req.index)
        `IDX_FOLLOWING_ERROR_WINDOW:   following_error_window_q  <= req.wdata;
        `IDX_FOLLOWING_ERROR_TIMEOUT:  following_error_timeout_q <= req.wdata[15:0];
        `IDX_POSITION_WINDOW:          position_window_q         <= req.wdata;
        `IDX_POSITION_WINDOW_TIME:     position_window_time_q    <= req.wdata[15:0];
        `IDX_VELOCITY_WINDOW:          velocity_window_q         <= req.wdata[15:0];
        `IDX_VELOCITY_WINDOW_TIME:     velocity_window_time_q    <= req.wdata[15:0];
        `IDX_VELOCITY_THRESHOLD:       velocity_threshold_q      <= req.wdata[15:0];
        `IDX_VELOCITY_THRESHOLD_TIME:  velocity_threshold_time_q <= req.wdata[15:0];
        `IDX_FOLLOWING_ERROR_REACTION: reaction_code_q           <= req.wdata[15:0];
        default: ;
      endcase
    end
  end

  // Object read mux; read-only indices answer with error on write, unknown indices on read or write
  always_comb begin
    object_ok  = 1'b1;
    read_value = 32'h00000000;
    unique case (req.index)
      `IDX_FOLLOWING_ERROR_WINDOW:   read_value = following_error_window_q;
      `IDX_FOLLOWING_ERROR_TIMEOUT:  read_value = {16'h0000, following_error_timeout_q};
      `IDX_POSITION_WINDOW:          read_value = position_window_q;
      `IDX_POSITION_WINDOW_TIME:     read_value = {16'h0000, position_window_time_q};
      `IDX_VELOCITY_DEMAND_VALUE: begin
        read_value = sample.velocity_demand; // RULE10
        object_ok  = !req.write;
      end
      `IDX_VELOCITY_ACTUAL_VALUE: begin
        read_value = sample.velocity_actual;
        object_ok  = !req.write;
      end
      `IDX_VELOCITY_WINDOW:          read_value = {16'h0000, velocity_window_q};
      `IDX_VELOCITY_WINDOW_TIME:     read_value = {16'h0000, velocity_window_time_q};
      `IDX_VELOCITY_THRESHOLD:       read_value = {16'h0000, velocity_threshold_q};
      `IDX_VELOCITY_THRESHOLD_TIME:  read_value = {16'h0000, velocity_threshold_time_q};
      `IDX_FOLLOWING_ERROR_REACTION: read_value = {16'h0000, reaction_code_q};
      default:                       object_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.read || req.write;
      rsp.error <= (req.read || req.write) && !object_ok;
      rsp.rdata <= (req.read && object_ok) ? read_value : 32'h00000000;
    end
  end

endmodule

// [motion_window_cfg.svh]
// Object indices, preset values and timing counts of the motion window monitor.
// Assumes a 125 MHz system clock.
`ifndef MOTION_WINDOW_CFG_SVH
`define MOTION_WINDOW_CFG_SVH
`define IDX_FOLLOWING_ERROR_WINDOW   16'h6065
`define IDX_FOLLOWING_ERROR_TIMEOUT  16'h6066
`define IDX_POSITION_WINDOW          16'h6067
`define IDX_POSITION_WINDOW_TIME     16'h6068
`define IDX_VELOCITY_DEMAND_VALUE    16'h606B
`define IDX_VELOCITY_ACTUAL_VALUE    16'h606C
`define IDX_VELOCITY_WINDOW          16'h606D
`define IDX_VELOCITY_WINDOW_TIME     16'h606E
`define IDX_VELOCITY_THRESHOLD       16'h606F
`define IDX_VELOCITY_THRESHOLD_TIME  16'h6070
`define IDX_FOLLOWING_ERROR_REACTION 16'h3700
`define RST_FOLLOWING_ERROR_WINDOW   32'h00000100
`define RST_FOLLOWING_ERROR_TIMEOUT  16'h0064
`define RST_POSITION_WINDOW          32'h0000000A
`define RST_POSITION_WINDOW_TIME     16'h0064
`define RST_VELOCITY_WINDOW          16'h001E
`define RST_VELOCITY_WINDOW_TIME     16'h0000
`define RST_VELOCITY_THRESHOLD       16'h0000
`define RST_VELOCITY_THRESHOLD_TIME  16'h0000
`define RST_FOLLOWING_ERROR_REACTION 16'h0000
`define WINDOW_OFF                   32'hFFFFFFFF
`define STATUS_TARGET_REACHED_BIT    10
`define STATUS_SPEED_ZERO_BIT        12
`define STATUS_FOLLOWING_ERROR_BIT   13
`define CLOCK_HZ                     125000000
`define TICK_MS                      1
`define TICK_CYCLES                  ((`CLOCK_HZ / 1000) * `TICK_MS)
`endif

// [motion_window_pkg.sv]
// Types shared by the motion window monitor.
// Assumes the configuration header is included by the users of these types.
package motion_window_pkg;
  typedef enum logic [7:0] {
    mode_none             = 8'h00,
    mode_profile_position = 8'h01,
    mode_velocity         = 8'h02,
    mode_profile_velocity = 8'h03,
    mode_interp_position  = 8'h07
  } op_mode_type;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] index;
    logic [31:0] wdata;
  } object_req_type;

  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] rdata;
  } object_rsp_type;

  typedef struct packed {
    logic signed [31:0] target_position;
    logic signed [31:0] position_demand;
    logic signed [31:0] position_actual;
    logic signed [31:0] velocity_target;
    logic signed [31:0] velocity_demand;
    logic signed [31:0] velocity_actual;
  } motion_sample_type;
endpackage

// [motion_window_checker.sv]
// Port assertions of the motion window monitor.
// Assumes it is bound into the monitor and sees only its ports.
`include "motion_window_cfg.svh"
module motion_window_checker
  import motion_window_pkg::*;
#(
  parameter int TICK_COUNT = 10
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire op_mode_type       op_mode,
  input wire motion_sample_type sample,
  input wire object_req_type    req,
  input wire object_rsp_type    rsp,
  input wire logic [15:0]       drive_status_word,
  input wire logic              following_error_reaction,
  input wire logic              error_history
);
  logic fe_dev, spd_nz, fe_bit, req_any, idx16;
  assign fe_dev = sample.position_actual != sample.position_demand;
  assign spd_nz = sample.velocity_actual != 32'h0;
  assign fe_bit = drive_status_word[13];
  assign req_any = req.read || req.write;
  assign idx16 = req.read && req.index inside {16'h6066, 16'h6068, 16'h606E};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_req; req_any; endsequence
  sequence s_logged; error_history && (fe_bit || $past(fe_bit)) ##1 !following_error_reaction;
  endsequence
  property p_answer; s_req |=> rsp.valid; endproperty
  property p_spurious; rsp.valid |-> $past(req_any); endproperty
  property p_ro; req.write && req.index inside {16'h606B, 16'h606C} |=> rsp.error; endproperty
  property p_zero_ext; idx16 |=> rsp.error || rsp.rdata[31:16] == 16'h0; endproperty
  property p_spare; (drive_status_word & 16'hCBFF) == 16'h0; endproperty
  property p_fe_cause; fe_bit |-> $past(fe_dev) || $past(fe_dev, 2); endproperty
  property p_speed; !drive_status_word[12] |-> $past(spd_nz) || $past(spd_nz, 2); endproperty
  property p_reaction; following_error_reaction |-> s_logged; endproperty
  property p_mode; $rose(drive_status_word[10]) |-> $past(op_mode) inside
    {mode_profile_position, mode_profile_velocity, mode_interp_position}; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_spurious: assert property (p_spurious) else $error("answer without request");
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  a_zero_ext: assert property (p_zero_ext) else $error("upper half not zero");
  a_spare: assert property (p_spare) else $error("unused status bit set");
  a_fe_cause: assert property (p_fe_cause) else $error("error bit without deviation");
  a_speed: assert property (p_speed) else $error("speed bit cleared at rest");
  a_reaction: assert property (p_reaction) else $error("reaction not logged");
  a_mode: assert property (p_mode) else $error("target bit in wrong mode");
endmodule
bind motion_window_monitor motion_window_checker #(.TICK_COUNT(TICK_COUNT)) motion_window_checker_i (
  .clk, .reset_n, .op_mode, .sample, .req, .rsp, .drive_status_word,
  .following_error_reaction, .error_history
);

// [motion_window_master.sv]
// Fieldbus master model issuing object accesses.
// Assumes requests are taken on a rising edge and answered one edge later.
module motion_window_master
  import motion_window_pkg::*;
(
  input  wire logic           clk,
  output object_req_type      req,
  input  wire object_rsp_type rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // Unanswered access leaves unknowns, so the caller's compare fails
  task automatic access(input logic w, input logic [15:0] i, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
    int k;
    rd = 'x;
    err = 1'bx;
    @(negedge clk);
    req = '{write: w, read: !w, index: i, wdata: d};
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      req = '0;
      if (rsp.valid === 1'b1) begin
        rd = rsp.rdata;
        err = rsp.error;
        break;
      end
    end
  endtask
endmodule

// [motion_window_monitor_tb_top.sv]
// Self-checking bench of the motion window monitor.
// Assumes a 10-cycle millisecond tick to keep dwell times short.
module motion_window_monitor_tb_top
  import motion_window_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, reset_n, fe_react, err_hist, err;
  op_mode_type       op_mode;
  motion_sample_type sample;
  object_req_type    req;
  object_rsp_type    rsp;
  logic [15:0]       dsw;
  logic [31:0]       rd;
  int                miscompares = 0, checks = 0, hist_seen = 0;
  logic [15:0] idx[8] = '{16'h6065, 16'h6066, 16'h6067, 16'h6068, 16'h606D, 16'h606E,
                          16'h606F, 16'h6070};
  logic [31:0] pre[8] = '{32'h100, 32'h64, 32'hA, 32'h64, 32'h1E, 32'h0, 32'h0, 32'h0};
  always #4 clk = ~clk;
  // Pulses stand from one rising edge to the next, so count them mid-cycle
  always @(negedge clk) if (fe_react === 1'b1 && err_hist === 1'b1) hist_seen <= hist_seen + 1;
  motion_window_monitor #(.TICK_COUNT(10)) motion_window_monitor_i (.clk, .reset_n, .op_mode,
    .sample, .req, .rsp, .drive_status_word(dsw), .following_error_reaction(fe_react),
    .error_history(err_hist));
  motion_window_master motion_window_master_i (.clk, .req, .rsp);
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic obj(input logic w, input logic [15:0] i, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    motion_window_master_i.access(w, i, d, rd, err);
    chk("error", ee, err);
    if (err !== 1'b0 && err !== 1'b1) conclude();
    if (!w) chk("rdata", e, rd);
  endtask
  // Equal bounds mean the bit must never reach v
  task automatic wait_bit(input int b, input logic v, input int lo, input int hi);
    int i;
    logic hit;
    hit = 0;
    for (i = 0; i < hi && !hit; i++) begin
      @(negedge clk);
      hit = dsw[b] === v;
    end
    chk("status timing", 1, lo < hi ? hit && i > lo : !hit);
    if (lo < hi && !hit) conclude();
  endtask
  initial begin
    clk = 0;
    reset_n = 0;
    op_mode = mode_profile_position;
    sample = '0;
    sample.target_position = 32'h1000;
    sample.velocity_target = 32'h3E8;
    repeat (3) @(negedge clk);
    reset_n = 1;
    chk("status", 16'h1000, dsw);
    foreach (idx[k]) obj(0, idx[k], 0, pre[k], 0);
    obj(1, 16'h606B, 32'h5, 0, 1);
    sample.velocity_demand = 32'h12345678;
    obj(0, 16'h606B, 0, 32'h12345678, 0);
    obj(0, 16'h6000, 0, 0, 1);
    obj(1, 16'h3700, 1, 0, 0);
    obj(1, 16'h6066, 32'hABCD0002, 0, 0);
    obj(0, 16'h6066, 0, 32'h2, 0);
    sample.position_actual = 32'h101;
    wait_bit(13, 1, 15, 60);
    chk("reaction", 1, fe_react);
    chk("history", 1, err_hist);
    sample.position_actual = 32'h100;
    wait_bit(13, 0, 0, 4);
    sample.position_actual = 32'h101;
    repeat (20) @(negedge clk);
    sample.position_actual = 32'h0;
    @(negedge clk);
    sample.position_actual = 32'h101;
    wait_bit(13, 1, 15, 60);
    sample.position_actual = 32'h0;
    obj(1, 16'h6065, 32'hFFFFFFFF, 0, 0);
    sample.position_actual = 32'h7FFF0000;
    wait_bit(13, 1, 60, 60);
    obj(1, 16'h6068, 3, 0, 0);
    sample.position_actual = 32'h1009;
    wait_bit(10, 1, 25, 70);
    sample.position_actual = 32'h100A;
    wait_bit(10, 0, 0, 4);
    op_mode = mode_interp_position;
    sample.position_actual = 32'h1009;
    wait_bit(10, 1, 25, 70);
    op_mode = mode_velocity;
    wait_bit(10, 0, 0, 4);
    op_mode = mode_profile_position;
    obj(1, 16'h6067, 32'hFFFFFFFF, 0, 0);
    wait_bit(10, 1, 60, 60);
    op_mode = mode_profile_velocity;
    obj(1, 16'h606E, 2, 0, 0);
    sample.velocity_actual = 32'h405;
    wait_bit(10, 1, 15, 60);
    sample.velocity_actual = 32'h406;
    wait_bit(10, 0, 0, 4);
    chk("speed bit", 0, dsw[12]);
    obj(1, 16'h606F, 32'h7D0, 0, 0);
    obj(1, 16'h6070, 2, 0, 0);
    wait_bit(12, 1, 0, 6);
    sample.velocity_actual = 32'h7D1;
    wait_bit(12, 0, 9, 50);
    obj(0, 16'h606C, 0, 32'h7D1, 0);
    obj(1, 16'h606C, 32'h1, 0, 1);
    chk("history count", 2, hist_seen);
    conclude();
  end
endmodule
